// file: verilog/gpt_timer.sv
// general purpose timer pair with ahb-lite register slave
//
// How it works
// - two 16-bit halves, split or joined 32-bit
// - each half: counter, match, prescale, load
// - 32-bit config acts only as one timer
// - converter trigger ORed with other timer blocks
// - prescaler only in 16-bit one-shot and periodic
// - debug halt stalls one-shot and periodic counting when stall set
// - capture counts edges or records edge time
// - simple pwm with optional output inversion
// - pins stay gpio until alternate select set
// - reset leaves block idle, controls cleared
// - counters and loads reset to all ones
// - prescale counters and registers reset zero
// - config 0 timer, 1 real-time clock
// - config 4 splits into two halves
// - zero reloads; one-shot stops, clears enable
// - raw flag sticks until cleared; masked view
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module gpt_timer
  import gpt_pkg::*;
#(
  parameter int unsigned RTC_DIV = gpt_pkg::RTC_DIV_DEF // edges per rtc tick
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire gpt_pkg::gpt_ahb_in_t ahb_i,
  output gpt_pkg::gpt_ahb_out_t ahb_o,
  input wire logic [1:0] ccp_i,
  input wire logic debug_halt,
  input wire logic adc_trig_other,
  output gpt_pkg::gpt_pin_out_t ccp_o,
  output logic adc_trig
);
  import gpt_pkg::*;

  // the divider counter is 16 bits wide
  if (RTC_DIV < 2 || RTC_DIV > 65536) begin : g_chk
    $error("RTC_DIV out of range");
  end

  localparam logic [15:0] RTC_LAST = 16'(RTC_DIV - 1);

  // whole block state
  typedef struct packed {
    gpt_bus_t bus_ph; // pending data phase
    logic [7:0] addr_q; // latched word offset
    logic [31:0] hrdata;
    logic hready;
    logic [2:0] cfg; // timer_config_select
    logic [1:0][3:0] mode;
    logic [15:0] ctl;
    logic [15:0] imr;
    logic [15:0] ris; // sticky raw flags
    logic [1:0][15:0] load;
    logic [1:0][15:0] match; // one match word per half
    logic [1:0][7:0] pre; // prescale reload value
    logic [1:0][7:0] pcnt; // running prescale count
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cap;
    logic [1:0] alt; // alt_function_select
    logic [1:0] pin_prev; // last synced pin level
    logic [15:0] rtc_div;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
    logic adc_trig;
  } gpt_timer_st_t;

  gpt_timer_st_t st_reg;
  gpt_timer_st_t st_next;
  logic [2:0] sync_q; // {halt, pin b, pin a}

  // pin and halt levels go through two flops first
  gpt_sync #(.W(3)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({debug_halt, ccp_i}),
    .q(sync_q)
  );

  // selected edge between two samples
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic fall);
    edge_hit = fall ? (prev & ~cur) : (~prev & cur);
  endfunction

  // control bit of one half
  function automatic logic ctl_bit(input logic [15:0] ctl, input int h,
                                   input int unsigned pos);
    ctl_bit = ctl[h * HALF_SHIFT + pos];
  endfunction

  always_comb begin
    logic acc;
    logic is32;
    logic halt;
    logic run;
    logic ev;
    logic [31:0] c32;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [15:0] set_m;
    logic [15:0] clr_m;
    st_next = st_reg;
    acc = 1'b0;
    is32 = 1'b0;
    halt = 1'b0;
    run = 1'b0;
    ev = 1'b0;
    c32 = 32'h0;
    wd = ahb_i.hwdata;
    rd = 32'h0;
    set_m = 16'h0;
    clr_m = 16'h0;
    halt = sync_q[2];
    is32 = (st_reg.cfg == CFG_32_TIMER) || (st_reg.cfg == CFG_32_RTC);
    c32 = {st_reg.cnt[1], st_reg.cnt[0]};
    st_next.adc_trig = adc_trig_other;
    st_next.pin_prev = sync_q[1:0];

    // counting per configuration
    unique case (st_reg.cfg)
      CFG_32_TIMER: begin
        // joined down-counter, enable and mode from half a
        run = st_reg.ctl[CTL_EN] & ~(st_reg.ctl[CTL_STALL] & halt);
        if (run) begin
          if (c32 == 32'h0) begin
            c32 = {st_reg.load[1], st_reg.load[0]};
            set_m[FLG_TO] = 1'b1;
            st_next.adc_trig = adc_trig_other | st_reg.ctl[CTL_OTE];
            if (st_reg.mode[0][1:0] == MODE_ONESHOT) begin
              st_next.ctl[CTL_EN] = 1'b0;
            end
          end else begin
            c32 = c32 - 32'h1;
          end
        end
        st_next.cnt[0] = c32[15:0];
        st_next.cnt[1] = c32[31:16];
      end
      CFG_32_RTC: begin
        // up-counter ticked by the even pin reference; no stall here
        ev = st_reg.alt[0] & edge_hit(st_reg.pin_prev[0], sync_q[0], 1'b0);
        if (st_reg.ctl[CTL_EN] && ev) begin
          if (st_reg.rtc_div == RTC_LAST) begin
            st_next.rtc_div = 16'h0;
            if (c32 == {st_reg.match[1], st_reg.match[0]}) begin
              c32 = 32'h0;
              set_m[FLG_RTC] = 1'b1;
            end else begin
              c32 = c32 + 32'h1;
            end
          end else begin
            st_next.rtc_div = st_reg.rtc_div + 16'h1;
          end
        end
        st_next.cnt[0] = c32[15:0];
        st_next.cnt[1] = c32[31:16];
      end
      CFG_16_SPLIT: begin
        // each half on its own mode
        for (int h = 0; h < 2; h++) begin
          // half a on the even pin, half b on the odd
          ev = st_reg.alt[h] & edge_hit(st_reg.pin_prev[h], sync_q[h],
                                        ctl_bit(st_reg.ctl, h, CTL_FALL));
          run = ctl_bit(st_reg.ctl, h, CTL_EN)
                & ~(ctl_bit(st_reg.ctl, h, CTL_STALL) & halt);
          if (st_reg.mode[h][MODE_PWM]) begin
            // pwm: no prescale, period from load, duty from match
            if (ctl_bit(st_reg.ctl, h, CTL_EN)) begin
              st_next.cnt[h] = (st_reg.cnt[h] == 16'h0) ? st_reg.load[h]
                               : st_reg.cnt[h] - 16'h1;
            end
            st_next.pin_o[h] = (ctl_bit(st_reg.ctl, h, CTL_EN)
                               & (st_reg.cnt[h] > st_reg.match[h]))
                               ^ ctl_bit(st_reg.ctl, h, CTL_INV);
          end else begin
            st_next.pin_o[h] = 1'b0;
            unique case (st_reg.mode[h][1:0])
              MODE_ONESHOT, MODE_PERIODIC: begin
                if (run && st_reg.pcnt[h] != 8'h0) begin
                  st_next.pcnt[h] = st_reg.pcnt[h] - 8'h1;
                end else if (run) begin
                  st_next.pcnt[h] = st_reg.pre[h];
                  if (st_reg.cnt[h] == 16'h0) begin
                    st_next.cnt[h] = st_reg.load[h];
                    set_m[h * HALF_SHIFT + FLG_TO] = 1'b1;
                    // or in, so a pulse of the other half is kept
                    st_next.adc_trig = st_next.adc_trig
                                       | ctl_bit(st_reg.ctl, h, CTL_OTE);
                    if (st_reg.mode[h][1:0] == MODE_ONESHOT) begin
                      st_next.ctl[h * HALF_SHIFT + CTL_EN] = 1'b0;
                    end
                  end else begin
                    st_next.cnt[h] = st_reg.cnt[h] - 16'h1;
                  end
                end
              end
              MODE_CAPTURE: begin
                if (!ctl_bit(st_reg.ctl, h, CTL_EN)) begin
                  // idle half keeps its count
                end else if (st_reg.mode[h][MODE_CAP_TIME]) begin
                  // free-running count, edge latches the time
                  st_next.cnt[h] = (st_reg.cnt[h] == 16'h0) ? st_reg.load[h]
                                   : st_reg.cnt[h] - 16'h1;
                  if (ev) begin
                    st_next.cap[h] = st_reg.cnt[h];
                    set_m[h * HALF_SHIFT + FLG_CE] = 1'b1;
                  end
                end else if (ev) begin
                  // edge count down to the match, then stop
                  if (st_reg.cnt[h] == st_reg.match[h]) begin
                    st_next.cnt[h] = st_reg.load[h];
                    set_m[h * HALF_SHIFT + FLG_CM] = 1'b1;
                    st_next.ctl[h * HALF_SHIFT + CTL_EN] = 1'b0;
                  end else begin
                    st_next.cnt[h] = st_reg.cnt[h] - 16'h1;
                  end
                end
              end
              default: begin
                // mode 0 leaves the half idle
              end
            endcase
          end
          // pin driven only in pwm with alternate select
          st_next.pin_oe[h] = st_reg.alt[h] & st_reg.mode[h][MODE_PWM];
        end
      end
      default: begin
        // unused configuration codes hold every counter
      end
    endcase
    if (st_reg.cfg != CFG_16_SPLIT) begin
      st_next.pin_o = 2'b00; // 32-bit modes drive no pin
      st_next.pin_oe = 2'b00;
    end

    // read data of the latched offset
    unique case (st_reg.addr_q)
      OFS_CFG: rd = {29'h0, st_reg.cfg};
      OFS_MODE_A: rd = {28'h0, st_reg.mode[0]};
      OFS_MODE_B: rd = {28'h0, st_reg.mode[1]};
      OFS_CTL: rd = {16'h0, st_reg.ctl};
      OFS_IMR: rd = {16'h0, st_reg.imr};
      OFS_RIS: rd = {16'h0, st_reg.ris};
      OFS_MIS: rd = {16'h0, st_reg.ris & st_reg.imr};
      OFS_LOAD_A: rd = {is32 ? st_reg.load[1] : 16'h0, st_reg.load[0]};
      OFS_LOAD_B: rd = {16'h0, st_reg.load[1]};
      OFS_MATCH_A: rd = {is32 ? st_reg.match[1] : 16'h0, st_reg.match[0]};
      OFS_MATCH_B: rd = {16'h0, st_reg.match[1]};
      OFS_PRE_A: rd = {24'h0, st_reg.pre[0]};
      OFS_PRE_B: rd = {24'h0, st_reg.pre[1]};
      OFS_CNT_A: rd = {is32 ? st_reg.cnt[1] : 16'h0, st_reg.cnt[0]};
      OFS_CNT_B: rd = {16'h0, st_reg.cnt[1]};
      OFS_ALT: rd = {30'h0, st_reg.alt};
      OFS_CAP_A: rd = {16'h0, st_reg.cap[0]};
      OFS_CAP_B: rd = {16'h0, st_reg.cap[1]};
      default: rd = 32'h0; // unmapped reads zero
    endcase

    // finish the pending data phase
    st_next.hready = 1'b1;
    st_next.bus_ph = BUS_IDLE;
    unique case (st_reg.bus_ph)
      BUS_IDLE: begin
      end
      BUS_READ: begin
        // one wait state so a write just before is seen
        st_next.hrdata = rd;
      end
      BUS_WRITE: begin
        // software wins over the counters for its own fields
        unique case (st_reg.addr_q)
          OFS_CFG: begin
            st_next.cfg = wd[2:0];
            if (wd[2:0] == CFG_32_RTC) begin
              st_next.cnt[0] = RTC_START[15:0];
              st_next.cnt[1] = RTC_START[31:16];
              st_next.rtc_div = 16'h0;
            end
          end
          OFS_MODE_A: st_next.mode[0] = wd[3:0];
          OFS_MODE_B: st_next.mode[1] = wd[3:0];
          OFS_CTL: st_next.ctl = wd[15:0];
          OFS_IMR: st_next.imr = wd[15:0];
          OFS_ICR: clr_m = wd[15:0];
          OFS_LOAD_A: begin
            // a new load is taken by the counter at once
            st_next.load[0] = wd[15:0];
            st_next.cnt[0] = wd[15:0];
            if (is32) begin
              st_next.load[1] = wd[31:16];
              st_next.cnt[1] = wd[31:16];
            end
          end
          OFS_LOAD_B: begin
            st_next.load[1] = wd[15:0];
            st_next.cnt[1] = wd[15:0];
          end
          OFS_MATCH_A: begin
            st_next.match[0] = wd[15:0];
            if (is32) begin
              st_next.match[1] = wd[31:16];
            end
          end
          OFS_MATCH_B: st_next.match[1] = wd[15:0];
          OFS_PRE_A: begin
            st_next.pre[0] = wd[7:0];
            st_next.pcnt[0] = wd[7:0];
          end
          OFS_PRE_B: begin
            st_next.pre[1] = wd[7:0];
            st_next.pcnt[1] = wd[7:0];
          end
          OFS_ALT: st_next.alt = wd[1:0];
          default: begin
            // writes to read-only or unmapped offsets are dropped
          end
        endcase
      end
      default: begin
      end
    endcase

    // sticky flags: a set in the clearing cycle survives
    st_next.ris = (st_reg.ris & ~clr_m) | set_m;

    // accept a new address phase
    acc = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
    if (acc) begin
      st_next.addr_q = {ahb_i.haddr[7:2], 2'b00};
      st_next.bus_ph = ahb_i.hwrite ? BUS_WRITE : BUS_READ;
      st_next.hready = ahb_i.hwrite;
    end
  end

  // single state register, cleared except hready, loads and counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.hready <= 1'b1;
      st_reg.load <= {LOAD_RST, LOAD_RST};
      st_reg.cnt <= {LOAD_RST, LOAD_RST};
      st_reg.pre <= {PRE_RST, PRE_RST};
      st_reg.pcnt <= {PRE_RST, PRE_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops, hresp tied low
  assign ahb_o.hrdata = st_reg.hrdata;
  assign ahb_o.hreadyout = st_reg.hready;
  assign ahb_o.hresp = 1'b0;
  assign ccp_o.out = st_reg.pin_o;
  assign ccp_o.oe = st_reg.pin_oe;
  assign adc_trig = st_reg.adc_trig;
endmodule

// file: pkg/gpt_pkg.sv
// shared constants, register map and carrier types of the timer pair
package gpt_pkg;
  // data widths
  localparam int unsigned HALF_W = 16; // one counter half
  localparam int unsigned PRE_W = 8; // prescaler width
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00; // timer_config_select
  localparam logic [7:0] OFS_MODE_A = 8'h04; // half a mode
  localparam logic [7:0] OFS_MODE_B = 8'h08; // half b mode
  localparam logic [7:0] OFS_CTL = 8'h0c; // run, stall, edge, trigger, invert
  localparam logic [7:0] OFS_IMR = 8'h18; // flag mask
  localparam logic [7:0] OFS_RIS = 8'h1c; // raw flags, read only
  localparam logic [7:0] OFS_MIS = 8'h20; // masked flags, read only
  localparam logic [7:0] OFS_ICR = 8'h24; // interrupt_clear_reg, write one
  localparam logic [7:0] OFS_LOAD_A = 8'h28; // half_a_interval_load
  localparam logic [7:0] OFS_LOAD_B = 8'h2c; // half_b_interval_load
  localparam logic [7:0] OFS_MATCH_A = 8'h30; // half a match
  localparam logic [7:0] OFS_MATCH_B = 8'h34; // half b match
  localparam logic [7:0] OFS_PRE_A = 8'h38; // half_a_prescale
  localparam logic [7:0] OFS_PRE_B = 8'h3c; // half_b_prescale
  localparam logic [7:0] OFS_CNT_A = 8'h48; // half a counter, read only
  localparam logic [7:0] OFS_CNT_B = 8'h4c; // half b counter, read only
  localparam logic [7:0] OFS_ALT = 8'h50; // alt_function_select per pin
  localparam logic [7:0] OFS_CAP_A = 8'h58; // half a captured time
  localparam logic [7:0] OFS_CAP_B = 8'h5c; // half b captured time
  // configuration select encodings
  localparam logic [2:0] CFG_32_TIMER = 3'h0; // 32-bit one-shot/periodic
  localparam logic [2:0] CFG_32_RTC = 3'h1; // 32-bit real-time clock
  localparam logic [2:0] CFG_16_SPLIT = 3'h4; // two 16-bit halves
  // mode register: [1:0] kind, [2] capture type, [3] pwm
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam int unsigned MODE_CAP_TIME = 2; // 1 = edge time, 0 = count
  localparam int unsigned MODE_PWM = 3;
  // control bits, half b sits HALF_SHIFT above half a
  localparam int unsigned CTL_EN = 0; // half_a_run_enable
  localparam int unsigned CTL_STALL = 1;
  localparam int unsigned CTL_FALL = 2; // 1 = falling edge events
  localparam int unsigned CTL_OTE = 5; // converter trigger enable
  localparam int unsigned CTL_INV = 6; // pwm output inversion
  localparam int unsigned HALF_SHIFT = 8;
  // flag bits, half b sits HALF_SHIFT above half a
  localparam int unsigned FLG_TO = 0; // timeout_raw_flag
  localparam int unsigned FLG_CM = 1; // capture count match
  localparam int unsigned FLG_CE = 2; // capture time event
  localparam int unsigned FLG_RTC = 3; // rtc match (half a only)
  // reset values
  localparam logic [15:0] LOAD_RST = 16'hffff;
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [31:0] RTC_START = 32'h0000_0001;
  // rtc reference and tick rate
  localparam int unsigned RTC_REF_HZ = 32768; // 32.768 KHz
  localparam int unsigned RTC_TICK_HZ = 1;
  localparam int unsigned RTC_DIV_DEF = RTC_REF_HZ / RTC_TICK_HZ;
  // bus phase
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } gpt_bus_t;
  // ahb-lite request group
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } gpt_ahb_in_t;
  // ahb-lite answer group
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } gpt_ahb_out_t;
  // capture/compare pin drive, index 0 even pin, 1 odd pin
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } gpt_pin_out_t;
endpackage

// file: verilog/gpt_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module gpt_sync #(
  parameter int unsigned W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1; // metastable stage, read only by s2
    logic [W-1:0] s2;
  } gpt_sync_st_t;
  gpt_sync_st_t sync_reg;
  gpt_sync_st_t sync_next;

  // shift one stage per clock
  always_comb begin
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  // constant reset, no port value at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;
endmodule

// file: bench/gpt_timer_sva.sv
// port-level assertions and covers for the timer pair
`timescale 1ns/1ns
module gpt_timer_sva
  import gpt_pkg::*;
#(
  parameter int unsigned RTC_DIV = gpt_pkg::RTC_DIV_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire gpt_pkg::gpt_ahb_in_t ahb_i,
  input wire gpt_pkg::gpt_ahb_out_t ahb_o,
  input wire logic [1:0] ccp_i,
  input wire logic debug_halt,
  input wire logic adc_trig_other,
  input wire gpt_pkg::gpt_pin_out_t ccp_o,
  input wire logic adc_trig
);
  logic taken; // transfer accepted at this edge
  logic alt_wr_reg; // data phase of a pin select write
  logic [1:0] alt_reg; // shadow of the pin select
  assign taken = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
  // shadow of the pin select, so pin drive can be tied to it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alt_wr_reg <= 1'b0;
      alt_reg <= 2'b00;
    end else if (ahb_i.hready) begin
      alt_wr_reg <= taken && ahb_i.hwrite &&
        ahb_i.haddr[7:2] == OFS_ALT[7:2];
      if (alt_wr_reg) begin
        alt_reg <= ahb_i.hwdata[1:0];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (!ahb_o.hresp)
    else $error("bus response not okay");
  a_read_wait: assert property (taken && !ahb_i.hwrite
    |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && ahb_i.hwrite |=> ahb_o.hreadyout)
    else $error("write stalled");
  a_wait_single: assert property (!ahb_o.hreadyout |=> ahb_o.hreadyout)
    else $error("wait longer than one cycle");
  a_rdata_holds: assert property ($changed(ahb_o.hrdata)
    |-> $rose(ahb_o.hreadyout))
    else $error("read data moved outside a read");
  a_trig_or: assert property (adc_trig_other |=> adc_trig)
    else $error("other trigger not passed on");
  a_pin_gated: assert property (1'b1 |->
    (ccp_o.oe & ~(alt_reg | $past(alt_reg))) == 2'b00)
    else $error("pin driven without alternate select");
  a_reset_quiet: assert property ($rose(hresetn) |->
    ccp_o == '0 && !adc_trig && ahb_o.hrdata == 32'h0)
    else $error("outputs not idle after reset");
  c_read: cover property (taken && !ahb_i.hwrite);
  c_timeout_trig: cover property ($rose(adc_trig) && !$past(adc_trig_other));
  c_pin_drive: cover property (ccp_o.oe[0] && ccp_o.out[0]);
endmodule

// file: bench/gpt_pin_src.sv
// event source model on the two capture/compare pins
`timescale 1ns/1ns
module gpt_pin_src #(
  parameter int unsigned HALF = 3 // cycles per level, two at least
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] run,
  output logic [1:0] pin
);
  int cnt; // cycles spent at the present level
  // running pins toggle; stopped pins stand low between bursts
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      pin <= 2'b00;
    end else begin
      cnt <= (cnt + 1 == HALF) ? 0 : cnt + 1;
      if (cnt + 1 == HALF) begin
        pin <= (pin ^ run) & run;
      end
    end
  end
endmodule

// file: bench/gpt_timer_tb.sv
// self-checking bench for the timer pair
`timescale 1ns/1ns
module gpt_timer_tb;
  import gpt_pkg::*;
  localparam int unsigned RTC_DIV = 4; // short rtc division
  logic hclk;
  logic hresetn;
  gpt_ahb_in_t req; // master drive, hready filled below
  gpt_ahb_in_t ahb_i;
  gpt_ahb_out_t ahb_o;
  logic [1:0] ccp_pin;
  logic [1:0] pin_run;
  logic debug_halt;
  logic adc_trig_other;
  gpt_pin_out_t ccp_o;
  logic adc_trig;
  int n_errors;
  int samples_checked;
  logic [31:0] gap; // cycles since the last trigger rise
  logic [31:0] last_gap;
  int n_rise;
  logic trig_q;
  // one slave, so its ready is the bus ready
  always_comb begin
    ahb_i = req;
    ahb_i.hready = ahb_o.hreadyout;
  end
  gpt_timer #(.RTC_DIV(RTC_DIV)) i_gpt_timer (.hclk(hclk), .hresetn(hresetn),
    .ahb_i(ahb_i), .ahb_o(ahb_o), .ccp_i(ccp_pin), .debug_halt(debug_halt),
    .adc_trig_other(adc_trig_other), .ccp_o(ccp_o), .adc_trig(adc_trig));
  gpt_pin_src i_gpt_pin_src (.hclk(hclk), .hresetn(hresetn), .run(pin_run),
    .pin(ccp_pin));
  // trigger period monitor, sampled where outputs are settled
  always @(negedge hclk) begin
    gap <= gap + 1;
    trig_q <= adc_trig;
    if (adc_trig === 1'b1 && trig_q === 1'b0) begin
      last_gap <= gap;
      gap <= 1;
      n_rise <= n_rise + 1;
    end
  end
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task give_up;
    n_errors++;
    $display("Error at %0t ns: wait ran out, got %h expected %h", $time,
      1'b0, 1'b1);
    finish_test();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // waits for hready at an edge, taking read data at that edge
  task wait_ready(output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge hclk);
    while (ahb_o.hreadyout !== 1'b1) begin
      if (n++ > 100) give_up();
      @(negedge hclk);
    end
    rd = ahb_o.hrdata;
    @(posedge hclk);
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    logic [31:0] unused;
    @(posedge hclk);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= {24'h0, a};
    req.hwrite <= wr;
    req.hsize <= 3'h2;
    wait_ready(unused);
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= wd;
    wait_ready(rd);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // polls a register until all bits of the mask are set
  task poll(input logic [7:0] a, input logic [31:0] mask);
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h0;
    while ((r & mask) !== mask) begin
      if (n++ > 60) give_up();
      bus(1'b0, a, 32'h0, r);
    end
    chk(r & mask, mask);
  endtask
  task tidy;
    pin_run <= 2'b00;
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'hffff_ffff);
    wr(OFS_ALT, 32'h0);
  endtask
  task test_reset;
    rd(OFS_CFG, 32'h0);
    rd(OFS_CTL, 32'h0);
    rd(OFS_ALT, 32'h0);
    rd(OFS_LOAD_A, 32'hffff_ffff);
    rd(OFS_LOAD_B, 32'h0000_ffff);
    rd(OFS_CNT_B, 32'h0000_ffff);
    rd(OFS_PRE_A, 32'h0);
    rd(OFS_PRE_B, 32'h0);
    rd(8'h60, 32'h0);
    wr(OFS_RIS, 32'hffff_ffff);
    rd(OFS_RIS, 32'h0);
    adc_trig_other <= 1'b1;
    @(posedge hclk);
    adc_trig_other <= 1'b0;
    @(negedge hclk);
    chk({31'h0, adc_trig}, 32'h1);
    $display("reset test done");
  endtask
  task test_oneshot;
    wr(OFS_LOAD_A, 32'h0001_0002);
    rd(OFS_LOAD_B, 32'h0000_0001);
    wr(OFS_MODE_A, 32'h1);
    wr(OFS_LOAD_A, 32'h20);
    wr(OFS_IMR, 32'h1);
    wr(OFS_CTL, 32'h1);
    poll(OFS_RIS, 32'h1);
    rd(OFS_CTL, 32'h0);
    rd(OFS_CNT_A, 32'h20);
    rd(OFS_MIS, 32'h1);
    wr(OFS_IMR, 32'h0);
    rd(OFS_MIS, 32'h0);
    rd(OFS_RIS, 32'h1);
    wr(OFS_ICR, 32'h1);
    rd(OFS_RIS, 32'h0);
    $display("one-shot test done");
  endtask
  task test_period(input logic [2:0] cfg, input logic [7:0] pre,
    input logic [31:0] exp);
    int n;
    int k;
    wr(OFS_CFG, {29'h0, cfg});
    wr(OFS_MODE_A, 32'h2);
    wr(OFS_PRE_A, {24'h0, pre});
    wr(OFS_LOAD_A, 32'h9);
    wr(OFS_CTL, (32'h1 << CTL_EN) | (32'h1 << CTL_OTE));
    n = n_rise + 3;
    k = 0;
    while (n_rise < n) begin
      if (k++ > 2000) give_up();
      @(posedge hclk);
    end
    chk(last_gap, exp);
    tidy();
    $display("periodic test done");
  endtask
  task test_stall;
    logic [31:0] r;
    debug_halt <= 1'b1;
    wr(OFS_CFG, {29'h0, CFG_16_SPLIT});
    wr(OFS_LOAD_A, 32'h1000);
    wr(OFS_CTL, (32'h1 << CTL_EN) | (32'h1 << CTL_STALL));
    rd(OFS_CNT_A, 32'h1000);
    debug_halt <= 1'b0;
    // two sync flops plus one full prescale period before looking
    repeat (8) @(posedge hclk);
    bus(1'b0, OFS_CNT_A, 32'h0, r);
    samples_checked++;
    if ((r < 32'h1000) !== 1'b1) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, r, 32'hfff);
    end
    tidy();
    $display("stall test done");
  endtask
  task test_capture;
    wr(OFS_MODE_A, 32'h3);
    wr(OFS_LOAD_A, 32'h3);
    wr(OFS_MATCH_A, 32'h1);
    wr(OFS_MODE_B, 32'h7);
    wr(OFS_CTL, (32'h1 << CTL_EN) | (32'h1 << (CTL_EN + HALF_SHIFT))
      | (32'h1 << (CTL_FALL + HALF_SHIFT)));
    pin_run <= 2'b11;
    repeat (40) @(posedge hclk);
    rd(OFS_RIS, 32'h0);
    wr(OFS_ALT, 32'h3);
    poll(OFS_RIS, 32'h402);
    rd(OFS_CTL, 32'h500);
    tidy();
    $display("capture test done");
  endtask
  task test_pwm;
    int hi;
    wr(OFS_MODE_A, 32'ha);
    wr(OFS_LOAD_A, 32'h9);
    wr(OFS_MATCH_A, 32'h2);
    wr(OFS_ALT, 32'h1);
    for (int inv = 0; inv < 2; inv++) begin
      wr(OFS_CTL, (32'h1 << CTL_EN) | (32'(inv) << CTL_INV));
      repeat (4) @(posedge hclk);
      hi = 0;
      repeat (20) begin
        @(negedge hclk);
        hi += (ccp_o.out[0] === 1'b1);
      end
      chk(32'(hi), (inv == 1) ? 32'd6 : 32'd14);
      chk({30'h0, ccp_o.oe}, 32'h1);
    end
    tidy();
    $display("pwm test done");
  endtask
  task test_rtc;
    wr(OFS_CFG, {29'h0, CFG_32_RTC});
    wr(OFS_MATCH_A, 32'h3);
    wr(OFS_ALT, 32'h1);
    wr(OFS_CTL, 32'h1);
    rd(OFS_CNT_A, RTC_START);
    pin_run <= 2'b01;
    poll(OFS_RIS, 32'h1 << FLG_RTC);
    tidy();
    $display("rtc test done");
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    req = '0;
    hresetn = 1'b0;
    pin_run = 2'b00;
    debug_halt = 1'b0;
    adc_trig_other = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    gap = 32'h0;
    last_gap = 32'h0;
    n_rise = 0;
    trig_q = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    test_reset();
    test_oneshot();
    test_period(CFG_32_TIMER, 8'h00, 32'd10);
    test_period(CFG_16_SPLIT, 8'h02, 32'd30);
    test_stall();
    test_capture();
    test_pwm();
    test_rtc();
    finish_test();
  end
endmodule
bind gpt_timer gpt_timer_sva #(.RTC_DIV(RTC_DIV)) i_gpt_timer_sva (
  .hclk(hclk), .hresetn(hresetn), .ahb_i(ahb_i), .ahb_o(ahb_o),
  .ccp_i(ccp_i), .debug_halt(debug_halt), .adc_trig_other(adc_trig_other),
  .ccp_o(ccp_o), .adc_trig(adc_trig));
